// ### pkg/mdsu_pkg.sv
// Shared constants and types of the multiply, divide and shift unit.
package mdsu_pkg;

  // ---------------------------------------------------------------
  // Register selection codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_BYTE0 = 3'h0;
  localparam logic [2:0] SEL_BYTE1 = 3'h1;
  localparam logic [2:0] SEL_BYTE2 = 3'h2;
  localparam logic [2:0] SEL_BYTE3 = 3'h3;
  localparam logic [2:0] SEL_BYTE4 = 3'h4;
  localparam logic [2:0] SEL_BYTE5 = 3'h5;
  localparam logic [2:0] SEL_CTRL  = 3'h6;

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int         CTL_CNT_LSB  = 0;
  localparam int         CTL_CNT_MSB  = 4;
  localparam int         CTL_DIR_BIT  = 5;
  localparam int         CTL_NORM_BIT = 6;
  localparam logic [7:0] CTL_RST      = 8'h00;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         OSC_PER_MC     = 12;
  localparam int         DIV32_MC       = 6;
  localparam int         DIV16_MC       = 4;
  localparam int         MUL_MC         = 4;
  localparam int         SHIFT_MAX_MC   = 6;
  localparam int         SHIFT_PER_MC   = 6;
  localparam logic [3:0] PRESC_LAST     = 4'(OSC_PER_MC - 1);
  localparam int         DIV32_CLKS     = DIV32_MC * OSC_PER_MC;
  localparam int         DIV16_CLKS     = DIV16_MC * OSC_PER_MC;
  localparam int         MUL_CLKS       = MUL_MC * OSC_PER_MC;
  localparam int         SHIFT_MAX_CLKS = SHIFT_MAX_MC * OSC_PER_MC;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } mdsu_req_t;

  typedef enum logic [2:0] {
    OP_DIV32, OP_DIV16, OP_MUL, OP_SHL, OP_SHR, OP_NORM
  } mdsu_op_t;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_B0, SQ_B01, SQ_B012, SQ_B0123, SQ_D32, SQ_D16, SQ_M04, SQ_M041
  } mdsu_seq_t;

endpackage

// ### sim/mdsu_cpu_model.sv
// CPU core model that writes and reads the unit's byte registers.
`timescale 1ns/10ps
`default_nettype none
module mdsu_cpu_model (
  input  wire logic               sys_clk,
  input  wire logic [7:0]         rdata_ff,
  output var mdsu_pkg::mdsu_req_t sfr_req
);
  import mdsu_pkg::*;

  // ---------------------------------------------------------------
  // Register access tasks
  // ---------------------------------------------------------------
  initial sfr_req = '0;

  // A write raises its strobe 1 ns after an edge and holds it up to the taking edge.
  task automatic put(input logic [2:0] sel, input logic [7:0] dat);
    sfr_req = '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: dat};
    @(posedge sys_clk);
    #1;
  endtask

  // A read takes the data 1 ns after its taking edge.
  task automatic get(input logic [2:0] sel, output logic [7:0] dat);
    sfr_req = '{wr: 1'b0, rd: 1'b1, sel: sel, wdata: ~sfr_req.wdata};
    @(posedge sys_clk);
    #1;
    dat = rdata_ff;
  endtask

  // An idle cycle drops both strobes and scrambles the data lines.
  task automatic idle();
    sfr_req = '{wr: 1'b0, rd: 1'b0, sel: ~sfr_req.sel, wdata: ~sfr_req.wdata};
    @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### sim/mdsu_muldiv_unit_test.sv
// Self-checking bench of the multiply, divide and shift unit.
`timescale 1ns/10ps
`default_nettype none
module mdsu_muldiv_unit_test;
  import mdsu_pkg::*;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic       sys_clk;
  logic       rst_n;
  mdsu_req_t  sfr_req;
  logic [7:0] rdata_ff;
  logic       busy_ff;
  logic       done_ff;
  logic       seq_err_ff;
  int         n_errors;
  int         n_compared;
  int         n_busy;
  int         seed;
  int         cnt_tab[5] = '{0, 1, 6, 7, 31};

  mdsu_muldiv_unit i_dut (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sfr_req    (sfr_req),
    .rdata_ff   (rdata_ff),
    .busy_ff    (busy_ff),
    .done_ff    (done_ff),
    .seq_err_ff (seq_err_ff)
  );

  mdsu_cpu_model i_cpu (
    .sys_clk  (sys_clk),
    .rdata_ff (rdata_ff),
    .sfr_req  (sfr_req)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (busy_ff === 1'b1)
      n_busy <= n_busy + 1;
  end

  // ---------------------------------------------------------------
  // Helper tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_bytes(input int first, input int cnt, input logic [31:0] v);
    for (int i = 0; i < cnt; i++)
      i_cpu.put(3'(first + i), v[8*i +: 8]);
  endtask

  task automatic rd_bytes(input int first, input int cnt, output logic [31:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < cnt; i++)
    begin
      i_cpu.get(3'(first + i), b);
      v[8*i +: 8] = b;
    end
  endtask

  task automatic wait_done(input string what, input int exp_cyc);
    int k;
    k = 0;
    i_cpu.idle();
    while (busy_ff === 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 200)
    begin
      n_errors++;
      finish_test();
    end
    check({what, " done"}, done_ff, 32'h0000_0001);
    check({what, " cycles"}, n_busy, exp_cyc);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] v;
    logic [7:0]  c;
    int          n;
    seed = 32'h1e80_596e;
    n_errors = 0;
    n_compared = 0;
    n_busy = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    rd_bytes(0, 4, v);
    check("reset bytes", v, {4{BYTE_RST}});
    check("reset busy", busy_ff, 32'h0000_0000);
    $display("test reset done");
    i_cpu.put(SEL_BYTE0, 8'h12);
    i_cpu.put(SEL_BYTE2, 8'h34);
    check("order error", seq_err_ff, 32'h0000_0001);
    i_cpu.put(SEL_BYTE5, 8'h56);
    check("no start", busy_ff, 32'h0000_0000);
    i_cpu.put(3'h7, 8'h5a);
    i_cpu.get(3'h7, c);
    check("unmapped", c, 32'h0000_0000);
    $display("test order done");
    for (int t = 0; t < 4; t++)
    begin
      a = (t == 0) ? 32'h0000_ffff : {16'h0000, 16'($random(seed))};
      b = (t == 0) ? 32'h0000_ffff : {16'h0000, 16'($random(seed))};
      n_busy = 0;
      i_cpu.put(SEL_BYTE0, a[7:0]);
      i_cpu.put(SEL_BYTE4, b[7:0]);
      i_cpu.put(SEL_BYTE1, a[15:8]);
      i_cpu.put(SEL_BYTE5, b[15:8]);
      if (t == 1)
      begin
        i_cpu.get(SEL_BYTE0, c);
        check("busy read", c, 32'h0000_0000);
        i_cpu.put(SEL_BYTE0, ~a[7:0]);
      end
      wait_done("mul", MUL_CLKS);
      rd_bytes(0, 4, v);
      check("product", v, a * b);
    end
    $display("test mul done");
    for (int t = 0; t < 4; t++)
    begin
      a = (t == 0) ? 32'hffff_ffff : 32'($random(seed));
      b = (t == 0) ? 32'h0000_0001 : {16'h0000, 16'($random(seed)) | 16'h0001};
      n_busy = 0;
      wr_bytes(0, 4, a);
      wr_bytes(4, 2, b);
      wait_done("div32", DIV32_CLKS);
      rd_bytes(0, 4, v);
      check("quotient32", v, a / b);
      rd_bytes(4, 2, v);
      check("remainder32", v, a % b);
      a = {16'h0000, 16'($random(seed))};
      n_busy = 0;
      wr_bytes(0, 2, a);
      wr_bytes(4, 2, b);
      wait_done("div16", DIV16_CLKS);
      rd_bytes(0, 2, v);
      check("quotient16", v, a / b);
      rd_bytes(4, 2, v);
      check("remainder16", v, a % b);
    end
    $display("test div done");
    foreach (cnt_tab[i])
    begin
      for (int d = 0; d < 2; d++)
      begin
        a = 32'($random(seed));
        n = cnt_tab[i];
        c = {1'($random(seed)), 1'b0, 1'(d), 5'(n)};
        n_busy = 0;
        wr_bytes(0, 4, a);
        i_cpu.put(SEL_CTRL, c);
        wait_done("shift", (n == 0) ? OSC_PER_MC : (n + 5) / SHIFT_PER_MC * OSC_PER_MC);
        rd_bytes(0, 4, v);
        check("shift result", v, (d == 1) ? a >> n : a << n);
      end
    end
    $display("test shift done");
    for (int t = 0; t < 4; t++)
    begin
      n = t * 8 + 1;
      a = (32'($random(seed)) | 32'h8000_0000) >> n;
      c = {1'($random(seed)), 1'b1, 1'($random(seed)), 5'h00};
      b = {24'h00_0000, c};
      n_busy = 0;
      wr_bytes(0, 4, a);
      i_cpu.put(SEL_CTRL, c);
      wait_done("norm", (n + 5) / SHIFT_PER_MC * OSC_PER_MC);
      rd_bytes(0, 4, v);
      check("norm result", v, a << n);
      i_cpu.get(SEL_CTRL, c);
      check("norm count", c, {b[7:5], 5'(n)});
    end
    $display("test norm done");
    finish_test();
  end
endmodule
`default_nettype wire

// ### verilog/mdsu_muldiv_unit.sv
// Multiply, divide, normalize and shift unit reached through seven byte registers.
// Functional notes
// - Divide 32/16, 16/16, multiply, normalize, shift.
// - All operands and results are unsigned.
// - Takes 6, 4, 4, at most 6 machine cycles.
// - Shifts move up to six bits per cycle.
// - Six data bytes plus one control register.
// - Write order selects the operation.
// - Shift: bytes 0-3, control write starts it.
// - Division operands placed; byte 5 write starts.
// - Quotient low bytes, remainder in bytes 4-5.
// - Product in bytes 0-3, low first.
// - Lower register holds less significant byte.
`timescale 1ns/10ps
`default_nettype none
module mdsu_muldiv_unit (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire mdsu_pkg::mdsu_req_t sfr_req,
  output logic [7:0]              rdata_ff,
  output logic                    busy_ff,
  output logic                    done_ff,
  output logic                    seq_err_ff
);
  import mdsu_pkg::*;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] n;
    n = 6'd32;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
      begin
        n = 6'(31 - i);
      end
    end
    return n;
  endfunction

  function automatic logic [5:0] cap_step(input logic [5:0] v);
    return (v > 6'(SHIFT_PER_MC)) ? 6'(SHIFT_PER_MC) : v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  md_ff [6];
  logic [7:0]  ctl_ff;
  mdsu_seq_t   seq_ff;
  mdsu_seq_t   nxt_seq;
  mdsu_op_t    op_ff;
  logic [31:0] op_a_ff;
  logic [15:0] op_b_ff;
  logic [3:0]  presc_ff;
  logic [2:0]  mc_cnt_ff;
  logic [5:0]  shift_left_ff;
  logic [4:0]  norm_cnt_ff;
  logic        wr_ok;
  logic        start;
  mdsu_op_t    nxt_op;
  logic        mc_tick;
  logic        finish;
  logic [5:0]  step;
  logic [5:0]  lz;
  logic [31:0] acc;
  logic [31:0] quo;
  logic [15:0] rem;
  logic [31:0] prod;

  assign wr_ok   = sfr_req.wr && !busy_ff;
  assign mc_tick = busy_ff && (presc_ff == PRESC_LAST);
  assign acc     = {md_ff[3], md_ff[2], md_ff[1], md_ff[0]};
  assign lz      = lead_zeros(acc);

  // ---------------------------------------------------------------
  // Write order decoding
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_seq = SQ_IDLE;
    start   = 1'b0;
    nxt_op  = OP_MUL;
    if (sfr_req.sel == SEL_BYTE0)
    begin
      nxt_seq = SQ_B0;
    end
    else
    begin
      unique case (seq_ff)
        SQ_B0:
        begin
          if (sfr_req.sel == SEL_BYTE1) nxt_seq = SQ_B01;
          if (sfr_req.sel == SEL_BYTE4) nxt_seq = SQ_M04;
        end
        SQ_B01:
        begin
          if (sfr_req.sel == SEL_BYTE2) nxt_seq = SQ_B012;
          if (sfr_req.sel == SEL_BYTE4) nxt_seq = SQ_D16;
        end
        SQ_B012:
        begin
          if (sfr_req.sel == SEL_BYTE3) nxt_seq = SQ_B0123;
        end
        SQ_B0123:
        begin
          if (sfr_req.sel == SEL_BYTE4) nxt_seq = SQ_D32;
          if (sfr_req.sel == SEL_CTRL)
          begin
            start  = 1'b1;
            nxt_op = sfr_req.wdata[CTL_NORM_BIT] ? OP_NORM :
                     sfr_req.wdata[CTL_DIR_BIT] ? OP_SHR : OP_SHL;
          end
        end
        SQ_D32:
        begin
          start  = (sfr_req.sel == SEL_BYTE5);
          nxt_op = OP_DIV32;
        end
        SQ_D16:
        begin
          start  = (sfr_req.sel == SEL_BYTE5);
          nxt_op = OP_DIV16;
        end
        SQ_M04:
        begin
          if (sfr_req.sel == SEL_BYTE1) nxt_seq = SQ_M041;
        end
        SQ_M041:
        begin
          start  = (sfr_req.sel == SEL_BYTE5);
          nxt_op = OP_MUL;
        end
        SQ_IDLE:
        begin
          nxt_seq = SQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_ff     <= SQ_IDLE;
      seq_err_ff <= 1'b0;
    end
    else
    begin
      seq_err_ff <= wr_ok && !start && (nxt_seq == SQ_IDLE);
      if (wr_ok)
      begin
        seq_ff <= start ? SQ_IDLE : nxt_seq;
      end
    end
  end

  // ---------------------------------------------------------------
  // Machine cycle timing
  // ---------------------------------------------------------------
  assign step = (op_ff == OP_NORM) ? cap_step(lz) : cap_step(shift_left_ff);

  always_comb
  begin
    finish = 1'b0;
    if (mc_tick)
    begin
      unique case (op_ff)
        OP_DIV32: finish = (mc_cnt_ff == 3'(DIV32_MC - 1));
        OP_DIV16: finish = (mc_cnt_ff == 3'(DIV16_MC - 1));
        OP_MUL:   finish = (mc_cnt_ff == 3'(MUL_MC - 1));
        OP_NORM:  finish = (lz <= 6'(SHIFT_PER_MC)) || (acc == 32'h0000_0000);
        OP_SHL,
        OP_SHR:   finish = (shift_left_ff <= 6'(SHIFT_PER_MC));
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      presc_ff  <= 4'h0;
      mc_cnt_ff <= 3'h0;
      op_ff     <= OP_MUL;
    end
    else
    begin
      done_ff <= finish;
      if (wr_ok && start)
      begin
        busy_ff   <= 1'b1;
        presc_ff  <= 4'h0;
        mc_cnt_ff <= 3'h0;
        op_ff     <= nxt_op;
      end
      else if (busy_ff)
      begin
        presc_ff <= (presc_ff == PRESC_LAST) ? 4'h0 : presc_ff + 4'h1;
        if (mc_tick)
        begin
          mc_cnt_ff <= mc_cnt_ff + 3'h1;
        end
        if (finish)
        begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  always_comb
  begin
    prod = op_a_ff[15:0] * op_b_ff;
    quo  = 32'hFFFF_FFFF;
    rem  = op_a_ff[15:0];
    if (op_b_ff != 16'h0000)
    begin
      if (op_ff == OP_DIV16)
      begin
        quo = {16'h0000, op_a_ff[15:0] / op_b_ff};
        rem = op_a_ff[15:0] % op_b_ff;
      end
      else
      begin
        quo = op_a_ff / {16'h0000, op_b_ff};
        rem = 16'(op_a_ff % {16'h0000, op_b_ff});
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_a_ff <= 32'h0000_0000;
      op_b_ff <= 16'h0000;
    end
    else if (wr_ok && start)
    begin
      op_a_ff <= (nxt_op == OP_MUL) ? {16'h0000, md_ff[1], md_ff[0]} : acc;
      op_b_ff <= {sfr_req.wdata, md_ff[4]};
    end
  end

  // ---------------------------------------------------------------
  // Data bytes and control register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 6; i++)
      begin
        md_ff[i] <= BYTE_RST;
      end
      ctl_ff        <= CTL_RST;
      shift_left_ff <= 6'h00;
      norm_cnt_ff   <= 5'h00;
    end
    else if (wr_ok)
    begin
      if (sfr_req.sel == SEL_CTRL)
      begin
        ctl_ff        <= sfr_req.wdata;
        shift_left_ff <= {1'b0, sfr_req.wdata[CTL_CNT_MSB:CTL_CNT_LSB]};
        norm_cnt_ff   <= 5'h00;
      end
      else if (sfr_req.sel <= SEL_BYTE5)
      begin
        md_ff[sfr_req.sel] <= sfr_req.wdata;
      end
    end
    else if (finish && (op_ff == OP_DIV32 || op_ff == OP_DIV16))
    begin
      {md_ff[1], md_ff[0]} <= quo[15:0];
      if (op_ff == OP_DIV32)
      begin
        {md_ff[3], md_ff[2]} <= quo[31:16];
      end
      {md_ff[5], md_ff[4]} <= rem;
    end
    else if (finish && op_ff == OP_MUL)
    begin
      {md_ff[3], md_ff[2], md_ff[1], md_ff[0]} <= prod;
    end
    else if (mc_tick && (op_ff == OP_SHL || op_ff == OP_SHR || op_ff == OP_NORM))
    begin
      if (op_ff == OP_SHR)
      begin
        {md_ff[3], md_ff[2], md_ff[1], md_ff[0]} <= acc >> step;
      end
      else
      begin
        {md_ff[3], md_ff[2], md_ff[1], md_ff[0]} <= acc << step;
      end
      shift_left_ff <= shift_left_ff - step;
      norm_cnt_ff   <= norm_cnt_ff + step[4:0];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 8'h00;
    end
    else if (sfr_req.rd)
    begin
      if (busy_ff)
      begin
        rdata_ff <= 8'h00;
      end
      else if (sfr_req.sel == SEL_CTRL)
      begin
        rdata_ff <= (op_ff == OP_NORM) ? {ctl_ff[7:5], norm_cnt_ff} : ctl_ff;
      end
      else if (sfr_req.sel <= SEL_BYTE5)
      begin
        rdata_ff <= md_ff[sfr_req.sel];
      end
      else
      begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [7:0] clk_cnt;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_cnt <= 8'h00;
    end
    else if (wr_ok && start)
    begin
      clk_cnt <= 8'h00;
    end
    else if (busy_ff)
    begin
      clk_cnt <= clk_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_div32_time: assert property ($fell(busy_ff) && op_ff == OP_DIV32 |-> clk_cnt == 8'(DIV32_CLKS))
    else $error("32/16 division took the wrong time.");
  a_div16_time: assert property ($fell(busy_ff) && op_ff == OP_DIV16 |-> clk_cnt == 8'(DIV16_CLKS))
    else $error("16/16 division took the wrong time.");
  a_mul_time: assert property ($fell(busy_ff) && op_ff == OP_MUL |-> clk_cnt == 8'(MUL_CLKS))
    else $error("Multiplication took the wrong time.");
  a_shift_bound: assert property (busy_ff |-> clk_cnt < 8'(SHIFT_MAX_CLKS))
    else $error("Operation ran past its longest time.");
  a_shift_step: assert property (busy_ff && op_ff == OP_SHL && mc_tick |=> acc == ($past(acc) << ($past(shift_left_ff) - shift_left_ff)) && $past(shift_left_ff) - shift_left_ff <= 6'(SHIFT_PER_MC))
    else $error("Shift step is wrong.");
  a_mul_result: assert property (done_ff && op_ff == OP_MUL |-> acc == op_a_ff[15:0] * op_b_ff)
    else $error("Product is wrong.");
  a_div_result: assert property (done_ff && op_ff == OP_DIV32 && op_b_ff != 16'h0000 |-> ({16'h0000, md_ff[5], md_ff[4]} < {16'h0000, op_b_ff}) && (acc * op_b_ff + {md_ff[5], md_ff[4]} == op_a_ff))
    else $error("Quotient or remainder is wrong.");
  a_bad_order: assert property (!busy_ff && sfr_req.wr && sfr_req.sel == SEL_BYTE5 && !(seq_ff inside {SQ_D32, SQ_D16, SQ_M041}) |=> !busy_ff)
    else $error("Out of order write started an operation.");
  a_ctrl_start: assert property (!busy_ff && sfr_req.wr && sfr_req.sel == SEL_CTRL && seq_ff == SQ_B0123 |=> busy_ff)
    else $error("Control write did not start a shift.");
  a_byte_store: assert property (!busy_ff && sfr_req.wr && sfr_req.sel == SEL_BYTE2 |=> md_ff[2] == $past(sfr_req.wdata))
    else $error("Data byte not stored.");
  a_norm_msb: assert property (done_ff && op_ff == OP_NORM && acc != 32'h0000_0000 |-> acc[31])
    else $error("Normalize left the top bit clear.");

  c_div32: cover property ($fell(busy_ff) && op_ff == OP_DIV32);
  c_mul: cover property ($fell(busy_ff) && op_ff == OP_MUL);
  c_norm: cover property ($fell(busy_ff) && op_ff == OP_NORM && norm_cnt_ff > 5'd6);
  c_bad: cover property (seq_err_ff);

endmodule
`default_nettype wire
